// file: shared/tsc_pkg.sv
// Package: register map, field layout and timing constants of the sensor readout block
package tsc_pkg;
    // ========================================================================
    // Register map (special function register space)
    localparam logic [7:0] SENSOR_CONTROL_ADDR   = 8'hD2;   // On page F
    localparam logic [7:0] RESULT_LOW_BYTE_ADDR  = 8'hD2;   // On page 0
    localparam logic [7:0] RESULT_HIGH_BYTE_ADDR = 8'hD3;   // On page 0
    localparam logic [3:0] PAGE_CONTROL          = 4'hF;
    localparam logic [3:0] PAGE_RESULT           = 4'h0;

    // ========================================================================
    // Control register fields
    localparam int START_BIT       = 7;
    localparam int DONE_BIT        = 6;
    localparam int CNVL_MSB        = 2;
    localparam int CNVL_LSB        = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET  = 8'h00;

    // ========================================================================
    // Timing
    localparam int SENSOR_PERIODS_PER_UNIT = 256;   // Sensor clocks per length unit
    localparam int SETTLE_TIME_US          = 32;    // Fixed overhead in microseconds
    localparam int CLK_FREQ_MHZ            = 125;
    localparam int SETTLE_CYCLES           = SETTLE_TIME_US * CLK_FREQ_MHZ;
    localparam int SENSOR_CNT_W            = 20;
    localparam int SETTLE_CNT_W            = 16;

    // ========================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        TSC_IDLE    = 3'b001,
        TSC_MEASURE = 3'b010,
        TSC_SETTLE  = 3'b100
    } tsc_state_e;
endpackage : tsc_pkg

// file: src/tsc_edge_sync.sv
// Module: two-flop synchroniser with a one-cycle rising-edge pulse
`timescale 1ns/100ps
module tsc_edge_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      rise_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic meta_next;
    logic sync_next;
    logic last_next;

    // ========================================================================
    // Next values; the first stage feeds only the second
    always_comb begin
        meta_next  = async_in;
        sync_next  = meta_reg;
        last_next  = sync_reg;
        rise_pulse = sync_reg & ~last_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end
endmodule : tsc_edge_sync

// file: src/tsc_sensor_ctrl.sv
// Module: control and readout of the die-temperature sensor registers
`timescale 1ns/100ps
module tsc_sensor_ctrl #(
    parameter int SENSOR_PERIODS = tsc_pkg::SENSOR_PERIODS_PER_UNIT,
    parameter int SETTLE_CYC     = tsc_pkg::SETTLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [3:0]  sfr_page,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        sensor_clk_in,
    input  wire logic [15:0] sensor_value,
    input  wire logic        sensor_irq_enable,
    output logic             sensor_irq,
    output logic             sensor_busy
);
    localparam logic [tsc_pkg::SENSOR_CNT_W-1:0] ONE_CNT = 20'h00001;

    logic                 start_reg;
    logic                 start_next;
    logic                 done_reg;
    logic                 done_next;
    logic [2:0]           cnvl_reg;
    logic [2:0]           cnvl_next;
    logic [7:0]           high_reg;
    logic [7:0]           high_next;
    logic [7:0]           low_reg;
    logic [7:0]           low_next;
    logic [7:0]           rdata_reg;
    logic [7:0]           rdata_next;
    logic                 irq_reg;
    logic                 irq_next;
    logic                 busy_reg;
    logic                 busy_next;
    tsc_pkg::tsc_state_e  state_reg;
    tsc_pkg::tsc_state_e  state_next;
    logic [tsc_pkg::SENSOR_CNT_W-1:0] tick_reg;
    logic [tsc_pkg::SENSOR_CNT_W-1:0] tick_next;
    logic [tsc_pkg::SENSOR_CNT_W-1:0] tick_goal;
    logic [tsc_pkg::SETTLE_CNT_W-1:0] settle_reg;
    logic [tsc_pkg::SETTLE_CNT_W-1:0] settle_next;
    logic                 sensor_tick;
    logic                 sel_control;
    logic                 sel_low;
    logic                 sel_high;
    logic                 launch;
    logic                 finish;

    // ========================================================================
    // Sensor clock arrives from the analog macro; count its rising edges
    tsc_edge_sync u_sensor_edge (
        .clk        (clk),
        .rst_n      (rst_n),
        .async_in   (sensor_clk_in),
        .rise_pulse (sensor_tick)
    );

    // ========================================================================
    // Address decode depends on the page as well as the address
    assign sel_control = (sfr_page == tsc_pkg::PAGE_CONTROL) &&
                         (sfr_addr == tsc_pkg::SENSOR_CONTROL_ADDR);
    assign sel_low     = (sfr_page == tsc_pkg::PAGE_RESULT) &&
                         (sfr_addr == tsc_pkg::RESULT_LOW_BYTE_ADDR);
    assign sel_high    = (sfr_page == tsc_pkg::PAGE_RESULT) &&
                         (sfr_addr == tsc_pkg::RESULT_HIGH_BYTE_ADDR);

    // Launch on the falling write of the start bit: one then zero
    assign launch = sfr_wr && sel_control && start_reg &&
                    !sfr_wdata[tsc_pkg::START_BIT];

    // Sensor-clock periods for the selected length: 256 * (2^(n+1) + 1)
    // Shift amount is one bit wider so that length 7 does not wrap to zero
    // Length is read live; rewriting it mid-measurement moves the goal
    assign tick_goal = tsc_pkg::SENSOR_CNT_W'(SENSOR_PERIODS) *
                       ((ONE_CNT << ({1'b0, cnvl_reg} + 4'h1)) + ONE_CNT);

    assign finish = (state_reg == tsc_pkg::TSC_SETTLE) &&
                    (settle_reg == tsc_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1));

    // ========================================================================
    // Sequencer: sensor-clock phase, then the fixed settle time
    always_comb begin
        state_next  = state_reg;
        tick_next   = tick_reg;
        settle_next = settle_reg;
        busy_next   = busy_reg;
        case (state_reg)
            tsc_pkg::TSC_IDLE: begin
                if (launch) begin
                    state_next = tsc_pkg::TSC_MEASURE;
                    tick_next  = '0;
                    busy_next  = 1'b1;
                end
            end
            tsc_pkg::TSC_MEASURE: begin
                if (sensor_tick) begin
                    tick_next = tick_reg + ONE_CNT;
                    if (tick_reg + ONE_CNT >= tick_goal) begin
                        state_next  = tsc_pkg::TSC_SETTLE;
                        settle_next = '0;
                    end
                end
            end
            tsc_pkg::TSC_SETTLE: begin
                settle_next = settle_reg + 1'b1;
                if (finish) begin
                    state_next = tsc_pkg::TSC_IDLE;
                    busy_next  = 1'b0;
                end
            end
            default: begin
                state_next = tsc_pkg::TSC_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= tsc_pkg::TSC_IDLE;
            tick_reg   <= '0;
            settle_reg <= '0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            tick_reg   <= tick_next;
            settle_reg <= settle_next;
            busy_reg   <= busy_next;
        end
    end

    // ========================================================================
    // Registers: software writes, hardware updates; set beats clear
    always_comb begin
        start_next = start_reg;
        done_next  = done_reg;
        cnvl_next  = cnvl_reg;
        high_next  = high_reg;
        low_next   = low_reg;
        irq_next   = 1'b0;
        if (sfr_wr && sel_control) begin
            start_next = sfr_wdata[tsc_pkg::START_BIT];
            cnvl_next  = sfr_wdata[tsc_pkg::CNVL_MSB:tsc_pkg::CNVL_LSB];
            // Software may only clear the flag; bits 5:3 are dropped
            if (!sfr_wdata[tsc_pkg::DONE_BIT]) begin
                done_next = 1'b0;
            end
        end
        if (sfr_wr && sel_low) begin
            low_next = sfr_wdata;
        end
        if (sfr_wr && sel_high) begin
            high_next = sfr_wdata;
        end
        // Both bytes load in the same cycle the flag sets, never split
        if (finish) begin
            high_next = sensor_value[15:8];
            low_next  = sensor_value[7:0];
            done_next = 1'b1;
            irq_next  = sensor_irq_enable;
        end
    end

    // Read data is registered so the bus sees a flop output
    always_comb begin
        rdata_next = 8'h00;
        if (sfr_rd) begin
            if (sel_control) begin
                rdata_next = {start_reg, done_reg, 3'b000, cnvl_reg};
            end else if (sel_low) begin
                rdata_next = low_reg;
            end else if (sel_high) begin
                rdata_next = high_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 1'b0;
            done_reg  <= 1'b0;
            cnvl_reg  <= 3'b000;
            high_reg  <= tsc_pkg::RESULT_RESET;
            low_reg   <= tsc_pkg::RESULT_RESET;
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
        end else begin
            start_reg <= start_next;
            done_reg  <= done_next;
            cnvl_reg  <= cnvl_next;
            high_reg  <= high_next;
            low_reg   <= low_next;
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
        end
    end

    assign sfr_rdata   = rdata_reg;
    assign sensor_irq  = irq_reg;
    assign sensor_busy = busy_reg;

    // ========================================================================
    // Checks: completion flag and interrupt
    a_done_sets: assert property (@(posedge clk) disable iff (!rst_n)
        finish |=> done_reg) else $error("done flag not set at finish");
    a_done_no_sw_set: assert property (@(posedge clk) disable iff (!rst_n)
        (!done_reg && !finish) |=> !done_reg) else $error("done flag set without finish");
    a_done_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (done_reg && !(sfr_wr && sel_control && !sfr_wdata[tsc_pkg::DONE_BIT]))
        |=> done_reg) else $error("done flag dropped without clear");
    a_irq_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        sensor_irq |-> $rose(done_reg) && $past(sensor_irq_enable))
        else $error("interrupt without done edge");
    a_irq_finish: assert property (@(posedge clk) disable iff (!rst_n)
        sensor_irq |-> $past(finish)) else $error("interrupt without finish");
    a_irq_single: assert property (@(posedge clk) disable iff (!rst_n)
        sensor_irq |=> !sensor_irq) else $error("interrupt longer than one cycle");
    a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (finish && !sensor_irq_enable) |=> !sensor_irq)
        else $error("interrupt not gated");

    // Checks: launch and measurement length
    a_launch_seq: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == tsc_pkg::TSC_IDLE && state_next == tsc_pkg::TSC_MEASURE)
        |-> start_reg && sfr_wr && sel_control) else $error("bad launch");
    a_no_launch: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == tsc_pkg::TSC_IDLE && !launch) |=> state_reg == tsc_pkg::TSC_IDLE)
        else $error("measurement began without launch");
    a_busy_launch: assert property (@(posedge clk) disable iff (!rst_n)
        launch |=> sensor_busy) else $error("busy not raised at launch");
    a_busy_state: assert property (@(posedge clk) disable iff (!rst_n)
        sensor_busy |-> state_reg != tsc_pkg::TSC_IDLE) else $error("busy while idle");
    // The goal is recomputed here in plain integer arithmetic from the rule
    a_goal_value: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == tsc_pkg::TSC_MEASURE) |-> tick_goal ==
        tsc_pkg::SENSOR_CNT_W'(SENSOR_PERIODS * (2 ** (int'(cnvl_reg) + 1) + 1)))
        else $error("sensor period goal wrong");
    a_settle_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == tsc_pkg::TSC_SETTLE) |-> settle_reg == '0)
        else $error("settle not from zero");
    a_settle_exit: assert property (@(posedge clk) disable iff (!rst_n)
        finish |=> state_reg == tsc_pkg::TSC_IDLE && !sensor_busy)
        else $error("sequencer not idle after finish");

    // Checks: result bytes
    a_high_load: assert property (@(posedge clk) disable iff (!rst_n)
        finish |=> high_reg == $past(sensor_value[15:8]))
        else $error("high byte wrong");
    a_low_load: assert property (@(posedge clk) disable iff (!rst_n)
        finish |=> low_reg == $past(sensor_value[7:0])) else $error("low byte wrong");
    a_both_load: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_reg) |-> {high_reg, low_reg} == $past(sensor_value))
        else $error("mixed result");
    a_result_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!finish && !(sfr_wr && (sel_low || sel_high))) |=> $stable({high_reg, low_reg}))
        else $error("result changed without load");

    // Checks: register reads, one cycle of data per strobe and zero otherwise
    a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sel_control) |=> sfr_rdata[5:3] == 3'b000 &&
        sfr_rdata[6] == $past(done_reg)) else $error("control read wrong");
    a_ctrl_fields: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sel_control) |=> sfr_rdata[7] == $past(start_reg) &&
        sfr_rdata[2:0] == $past(cnvl_reg)) else $error("control fields wrong");
    a_high_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sel_high) |=> sfr_rdata == $past(high_reg))
        else $error("high read wrong");
    a_low_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sel_low) |=> sfr_rdata == $past(low_reg))
        else $error("low read wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && !sel_control && !sel_low && !sel_high) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data without strobe");

    // Main scenarios: launch, finish with and without interrupt, longest length
    c_launch:  cover property (@(posedge clk) disable iff (!rst_n) launch);
    c_finish:  cover property (@(posedge clk) disable iff (!rst_n) finish);
    c_irq:     cover property (@(posedge clk) disable iff (!rst_n) sensor_irq);
    c_no_irq:  cover property (@(posedge clk) disable iff (!rst_n) finish && !sensor_irq_enable);
    c_longest: cover property (@(posedge clk) disable iff (!rst_n) finish && cnvl_reg == 3'h7);
endmodule : tsc_sensor_ctrl

// file: verif/temp_sensor_control_readout_bench.sv
// Testbench: self-checking bench for the sensor control and readout block
`timescale 1ns/100ps
module temp_sensor_control_readout_bench;
    // ========================================================================
    // Shortened counts so every conversion length fits in a short run
    localparam int SP    = 2;
    localparam int SC    = 4;
    localparam int LIMIT = 20000;

    logic        clk               = 1'b0;
    logic        rst_n             = 1'b0;
    logic [7:0]  sfr_addr          = 8'h00;
    logic [3:0]  sfr_page          = 4'h0;
    logic        sfr_wr            = 1'b0;
    logic        sfr_rd            = 1'b0;
    logic [7:0]  sfr_wdata         = 8'h00;
    logic [7:0]  sfr_rdata;
    logic        sensor_clk_in     = 1'b0;
    logic [15:0] sensor_value      = 16'h0000;
    logic        sensor_irq_enable = 1'b0;
    logic        sensor_irq;
    logic        sensor_busy;
    logic        rd_pend           = 1'b0;
    logic [7:0]  exp_q[$];
    int          irq_cnt           = 0;
    int          n_errors          = 0;
    int          cmp_count         = 0;

    // ========================================================================
    // Clocks: the sensor clock is free running and unrelated in phase
    always #4 clk = ~clk;
    always #16.3 sensor_clk_in = ~sensor_clk_in;

    tsc_sensor_ctrl #(
        .SENSOR_PERIODS (SP),
        .SETTLE_CYC     (SC)
    ) i_dut (
        .clk               (clk),
        .rst_n             (rst_n),
        .sfr_addr          (sfr_addr),
        .sfr_page          (sfr_page),
        .sfr_wr            (sfr_wr),
        .sfr_rd            (sfr_rd),
        .sfr_wdata         (sfr_wdata),
        .sfr_rdata         (sfr_rdata),
        .sensor_clk_in     (sensor_clk_in),
        .sensor_value      (sensor_value),
        .sensor_irq_enable (sensor_irq_enable),
        .sensor_irq        (sensor_irq),
        .sensor_busy       (sensor_busy)
    );

    // ========================================================================
    // Compare tasks, one per kind of result
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: read data got %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: value got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // One register access; a read notes its expected byte for the monitor
    task automatic acc(input logic w, input logic [3:0] pg, input logic [7:0] ad,
                       input logic [7:0] d);
        if (!w) begin
            exp_q.push_back(d);
        end
        @(posedge clk);
        sfr_page  <= pg;
        sfr_addr  <= ad;
        sfr_wdata <= d;
        sfr_wr    <= w;
        sfr_rd    <= !w;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        sfr_rd    <= 1'b0;
    endtask : acc

    // ========================================================================
    // Monitor: read data shows one cycle after the strobe; interrupts are counted
    always @(posedge clk) begin
        if (rd_pend) begin
            chk_rd(sfr_rdata, exp_q.pop_front());
        end
        rd_pend <= sfr_rd;
        if (sensor_irq === 1'b1) begin
            irq_cnt++;
        end
    end

    // One measurement of length n; the flag is left set when keep is true
    task automatic measure(input logic [2:0] n, input logic keep);
        int          ticks;
        int          cyc;
        logic [15:0] v;
        logic        en;
        ticks = SP * ((2 ** (int'(n) + 1)) + 1);
        v = 16'($urandom);
        en = 1'($urandom);
        sensor_value      <= v;
        sensor_irq_enable <= en;
        irq_cnt = 0;
        acc(1'b1, 4'hF, 8'hD2, 8'h80);
        acc(1'b1, 4'hF, 8'hD2, {5'h00, n});
        @(posedge clk);
        #1;
        chk_val(32'(sensor_busy), 32'h1);
        cyc = 1;
        while (sensor_busy !== 1'b0 && cyc < LIMIT) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (cyc >= LIMIT) begin
            n_errors++;
            give_verdict();
        end
        // Sensor edges are resampled, so allow one sensor period of slack each way, at 4 to 5 cycles per period
        chk_val(32'(cyc >= (ticks - 1) * 4 + SC && cyc <= (ticks + 1) * 5 + SC + 8), 32'h1);
        acc(1'b0, 4'hF, 8'hD2, {2'b01, 3'b000, n});
        acc(1'b0, 4'h0, 8'hD3, v[15:8]);
        acc(1'b0, 4'h0, 8'hD2, v[7:0]);
        chk_val(32'(irq_cnt), 32'(en));
        // A later change of the live value must not reach the held high byte
        sensor_value <= ~v;
        repeat (20) @(posedge clk);
        acc(1'b0, 4'hF, 8'hD2, {2'b01, 3'b000, n});
        acc(1'b0, 4'h0, 8'hD3, v[15:8]);
        if (!keep) begin
            acc(1'b1, 4'hF, 8'hD2, {5'h00, n});
            acc(1'b0, 4'hF, 8'hD2, {5'h00, n});
        end
    endtask : measure

    // ========================================================================
    // Main sequence
    initial begin
        void'($urandom(32'h8AEE234C));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, 4'hF, 8'hD2, 8'h00);
        acc(1'b0, 4'h0, 8'hD2, 8'h00);
        acc(1'b0, 4'h0, 8'hD3, 8'h00);
        acc(1'b0, 4'hF, 8'hD3, 8'h00);
        acc(1'b0, 4'h3, 8'hD2, 8'h00);
        acc(1'b1, 4'h0, 8'hD2, 8'hA5);
        acc(1'b1, 4'h0, 8'hD3, 8'h5A);
        acc(1'b1, 4'h3, 8'hD2, 8'hFF);
        acc(1'b0, 4'h0, 8'hD2, 8'hA5);
        acc(1'b0, 4'h0, 8'hD3, 8'h5A);
        // The flag cannot be set by a write; reserved bits are written as zero
        acc(1'b1, 4'hF, 8'hD2, 8'h45);
        acc(1'b0, 4'hF, 8'hD2, 8'h05);
        chk_val(32'(sensor_busy), 32'h0);
        for (int n = 0; n < 8; n++) begin
            measure(n[2:0], n == 7);
        end
        // Second reset while the flag and the result are held
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, 4'hF, 8'hD2, 8'h00);
        acc(1'b0, 4'h0, 8'hD2, 8'h00);
        acc(1'b0, 4'h0, 8'hD3, 8'h00);
        repeat (3) @(posedge clk);
        chk_val(32'(exp_q.size()), 32'h0);
        give_verdict();
    end
endmodule : temp_sensor_control_readout_bench
